//--- comparator_edge_defs.vh
// Register offsets, field positions and reset values of the comparator edge interrupt block.
`ifndef COMPARATOR_EDGE_DEFS_VH
`define COMPARATOR_EDGE_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL        12'h000
`define OFS_MODE           12'h004
`define OFS_EXT_IRQ_EN     12'h008
`define OFS_IRQ_STATUS     12'h00c
`define OFS_IRQ_MASK       12'h010

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTL_NEG_HYS_LSB    0
`define CTL_POS_HYS_LSB    2
`define CTL_LEVEL_BIT      5
`define CTL_ON_BIT         7
`define CTL_RESET          8'h00

// ----------------------------------------------------------------------------
// Mode, enable, status and mask fields
// ----------------------------------------------------------------------------
`define MODE_FALL_EN_BIT   4
`define MODE_RISE_EN_BIT   5
`define MODE_RESET         8'h00
`define EXT_CMP_BIT        0
`define EXT_RESET          8'h00
`define ST_FALL_BIT        0
`define ST_RISE_BIT        1
`define MASK_RESET         2'h0

`endif

//--- comparator_edge_interrupt_control.v
// Comparator control, edge detection, flags and interrupt request behind an APB slave.
//
// The APB slave port and the register offsets were left to the implementer.
`include "comparator_edge_defs.vh"

module comparator_edge_interrupt_control (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        comparator_raw,
    output reg         comparator_on,
    output reg  [1:0]  negative_hysteresis_sel,
    output reg  [1:0]  positive_hysteresis_sel,
    output reg         irq
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg  [2:0] sync;
    reg        level_prev;
    reg        rising_edge_irq_enable;
    reg        falling_edge_irq_enable;
    reg        ext_cmp_enable;
    reg        rising_edge_flag;
    reg        falling_edge_flag;
    reg  [1:0] irq_mask;

    wire       comparator_output_level = level_prev;
    wire       stable = (sync[1] == sync[2]);
    wire       setup  = psel & ~penable;
    wire       wr     = setup & pwrite & pstrb[0];
    wire       rd     = setup & ~pwrite;
    wire       rise_ev;
    wire       fall_ev;
    wire       next_rise_flag;
    wire       next_fall_flag;

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `OFS_CONTROL) || (a == `OFS_MODE) || (a == `OFS_EXT_IRQ_EN) ||
                        (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchroniser and edge detection
    // ------------------------------------------------------------------------
    // The level only moves once stages two and three agree, filtering metastable samples.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync       <= 3'h0;
            level_prev <= 1'b0;
        end else begin
            sync <= {sync[1:0], comparator_raw};
            if (stable)
                level_prev <= sync[2];
        end
    end

    // An output that is off produces no edges, so a disabled comparator stays quiet.
    assign rise_ev = comparator_on & stable & sync[2] & ~level_prev;
    assign fall_ev = comparator_on & stable & ~sync[2] & level_prev;

    // Hardware set wins over a software clear in the same cycle.
    assign next_rise_flag = (rise_ev & rising_edge_irq_enable) |
                            (rising_edge_flag &
                             ~(wr && paddr == `OFS_IRQ_STATUS && pwdata[`ST_RISE_BIT]));
    assign next_fall_flag = (fall_ev & falling_edge_irq_enable) |
                            (falling_edge_flag &
                             ~(wr && paddr == `OFS_IRQ_STATUS && pwdata[`ST_FALL_BIT]));

    // ------------------------------------------------------------------------
    // Registers and APB slave
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            comparator_on           <= 1'b0;
            negative_hysteresis_sel <= 2'h0;
            positive_hysteresis_sel <= 2'h0;
            rising_edge_irq_enable  <= 1'b0;
            falling_edge_irq_enable <= 1'b0;
            ext_cmp_enable          <= 1'b0;
            rising_edge_flag        <= 1'b0;
            falling_edge_flag       <= 1'b0;
            irq_mask                <= `MASK_RESET;
            prdata                  <= 32'h0;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
            irq                     <= 1'b0;
        end else begin
            rising_edge_flag  <= next_rise_flag;
            falling_edge_flag <= next_fall_flag;
            // Request is registered from the next flag values, in step with the flags; an edge whose mode enable bit is clear sets no flag.
            irq <= ext_cmp_enable &
                   ((next_rise_flag & irq_mask[`ST_RISE_BIT]) |
                    (next_fall_flag & irq_mask[`ST_FALL_BIT]));
            pready  <= setup;
            pslverr <= setup & ~is_mapped(paddr);
            if (wr) begin
                case (paddr)
                    `OFS_CONTROL: begin
                        comparator_on           <= pwdata[`CTL_ON_BIT];
                        negative_hysteresis_sel <= pwdata[`CTL_NEG_HYS_LSB +: 2];
                        positive_hysteresis_sel <= pwdata[`CTL_POS_HYS_LSB +: 2];
                    end
                    `OFS_MODE: begin
                        rising_edge_irq_enable  <= pwdata[`MODE_RISE_EN_BIT];
                        falling_edge_irq_enable <= pwdata[`MODE_FALL_EN_BIT];
                    end
                    `OFS_EXT_IRQ_EN: ext_cmp_enable <= pwdata[`EXT_CMP_BIT];
                    `OFS_IRQ_MASK:   irq_mask       <= pwdata[1:0];
                    default: ;
                endcase
            end
            if (rd) begin
                prdata <= 32'h0;
                case (paddr)
                    `OFS_CONTROL: begin
                        prdata[`CTL_ON_BIT]             <= comparator_on;
                        prdata[`CTL_LEVEL_BIT]          <= comparator_output_level;
                        prdata[`CTL_POS_HYS_LSB +: 2]   <= positive_hysteresis_sel;
                        prdata[`CTL_NEG_HYS_LSB +: 2]   <= negative_hysteresis_sel;
                    end
                    `OFS_MODE: begin
                        prdata[`MODE_RISE_EN_BIT] <= rising_edge_irq_enable;
                        prdata[`MODE_FALL_EN_BIT] <= falling_edge_irq_enable;
                    end
                    `OFS_EXT_IRQ_EN: prdata[`EXT_CMP_BIT] <= ext_cmp_enable;
                    `OFS_IRQ_STATUS: begin
                        prdata[`ST_RISE_BIT] <= rising_edge_flag;
                        prdata[`ST_FALL_BIT] <= falling_edge_flag;
                    end
                    `OFS_IRQ_MASK: prdata[1:0] <= irq_mask;
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

endmodule // comparator_edge_interrupt_control

//--- comparator_edge_interrupt_control_assertions.sv
// Port checker of the comparator edge interrupt block, with its bind.
module comparator_edge_checker (input ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, comparator_raw,
    comparator_on, irq, input [11:0] paddr, input [3:0] pstrb, input [31:0] pwdata, prdata, input [1:0]
    negative_hysteresis_sel, positive_hysteresis_sel);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire setup = psel && !penable;
    sequence s_calm; ($stable(comparator_raw) && comparator_on)[*5]; endsequence
    property p_ans; setup |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no ready after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_bad; setup && paddr >= 12'h014 |=> pslverr && pready && (pwrite || prdata == 32'h0); endproperty
    a_bad: assert property (p_bad) else $error("unmapped access not refused");
    property p_ctl; setup && pwrite && paddr == 12'h000 && pstrb[0] |=> comparator_on == pwdata[7]
        && {positive_hysteresis_sel, negative_hysteresis_sel} == pwdata[3:0]; endproperty
    a_ctl: assert property (p_ctl) else $error("control not applied");
    property p_keep; !(setup && pwrite && paddr == 12'h000) |=> $stable(comparator_on); endproperty
    a_keep: assert property (p_keep) else $error("enable moved");
    property p_lvl; s_calm ##0 (setup && !pwrite && paddr == 12'h000) |=> prdata[5] == $past(comparator_raw); endproperty
    a_lvl: assert property (p_lvl) else $error("level bit wrong");
    property p_rise; $rose(irq) |-> $past(comparator_on) || ($past(psel) && $past(pwrite)); endproperty
    a_rise: assert property (p_rise) else $error("irq rose without cause");
    property p_fall; $fell(irq) |-> $past(psel) && $past(pwrite); endproperty
    a_fall: assert property (p_fall) else $error("irq fell without write");
endmodule // comparator_edge_checker
bind comparator_edge_interrupt_control comparator_edge_checker u_chk (.*);

//--- comparator_analog_model.sv
// Behavioural analog comparator that feeds the raw decision into the block.
module comparator_analog_model (input comparator_on, input_above, output comparator_raw);
    timeunit 1ns;
    timeprecision 1ps;
    assign comparator_raw = comparator_on && input_above; // Powered down, it parks low.
endmodule // comparator_analog_model

//--- test_comparator_edge_interrupt_control.sv
// Self-checking bench of the comparator edge interrupt block.
`define CHK(n, e, s) begin #1; num_checks++; if ((s) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module test_comparator_edge_interrupt_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, vin = 0, pready, pslverr, irq;
    logic        comparator_raw, comparator_on;
    logic [1:0]  negative_hysteresis_sel, positive_hysteresis_sel;
    logic [3:0]  pstrb = 4'hf;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic        err;
    integer      num_errors = 0, num_checks = 0, seed = 32'h557f, cyc = 0, i, hys;
    always #5 ref_clk = ~ref_clk;
    comparator_edge_interrupt_control dut (.*);
    comparator_analog_model far (.comparator_on, .input_above(vin), .comparator_raw);
    task test_done(input integer hung);
        $display("Checks %0d errors %0d", num_checks, num_errors + hung);
        if (num_errors + hung == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) if (++cyc == 3000) test_done(1);
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk) penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    initial begin
        #25 rst_n <= 1'b1;
        hys = $random(seed) & 15;
        apb(1'b1, 12'h000, 32'h80 | hys);
        `CHK("hysteresis", hys, {positive_hysteresis_sel, negative_hysteresis_sel})
        // Interrupt sources are opened only after the single power-up write to the control register.
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h010, 32'h3);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 12'h004, i << 4);
            apb(1'b1, 12'h00c, 32'h3);
            vin <= 1'b1;
            repeat (8) @(posedge ref_clk);
            apb(1'b0, 12'h000, 32'h0);
            `CHK("control", 32'ha0 | hys, rd)
            `CHK("control error", 1'b0, err)
            vin <= 1'b0;
            repeat (8) @(posedge ref_clk);
            apb(1'b0, 12'h00c, 32'h0);
            `CHK("status", i, rd)
            `CHK("irq", i != 0, irq)
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 12'h008, i & 1);
            apb(1'b1, 12'h010, (i & 2) ? 32'h3 : 32'h0);
            `CHK("irq", i == 3, irq)
        end
        apb(1'b1, 12'h00c, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("status", 32'h2, rd)
        apb(1'b0, 12'h040, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, 12'h000, 32'h20);
        `CHK("enable", 1'b0, comparator_on)
        $display("Edge and register tests done");
        test_done(0);
    end
endmodule // test_comparator_edge_interrupt_control
